// ### inc/prcd_defines.svh
`ifndef PRCD_DEFINES_SVH
`define PRCD_DEFINES_SVH

// register byte offsets
`define PRCD_OFS_CAPTURE0 8'h00
`define PRCD_OFS_CAPTURE1 8'h04
`define PRCD_OFS_MULTS 8'h08
`define PRCD_OFS_CORES 8'h0C
`define PRCD_OFS_STATUS 8'h10
`define PRCD_OFS_LBCTRL 8'h14

// local bus divider field
`define PRCD_LB_DIV_LSB 0
`define PRCD_LB_DIV_RST 5'h08
`define PRCD_LB_DIV_MIN 5'h02

// ratio code limits
`define PRCD_PLAT_MIN 5'h04
`define PRCD_PLAT_MAX 5'h0A
`define PRCD_CL_MIN 5'h08
`define PRCD_CL_MAX 5'h12
`define PRCD_MEM_SYNC_CODE 5'h01

// source select codes
`define PRCD_SRC_ONE_DIV1 4'h0
`define PRCD_SRC_ONE_DIV2 4'h1
`define PRCD_SRC_TWO_DIV1 4'h4
`define PRCD_SRC_TWO_DIV2 4'h5

// status bit positions
`define PRCD_ST_DONE 0
`define PRCD_ST_ERR 1
`define PRCD_ST_SYNC 2
`define PRCD_ST_SLOW_LSB 4

`endif

// ### inc/prcd_pkg.sv
`default_nettype none

package prcd_pkg;

   typedef enum logic [1:0] {
      PRCD_BUS_IDLE = 2'b01,
      PRCD_BUS_DATA = 2'b10
   } prcd_bus_state_t;

   typedef enum logic [1:0] {
      PRCD_MEM_ASYNC = 2'b01,
      PRCD_MEM_SYNC = 2'b10
   } prcd_mem_mode_t;

   typedef logic [4:0] prcd_ratio_t;

endpackage : prcd_pkg

`default_nettype wire

// ### logic/prcd_lb_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "prcd_defines.svh"

module prcd_lb_div (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // divider ratio
   input wire prcd_pkg::prcd_ratio_t ratio,
   // divided clock
   output logic [1:0] clk_out
);
   import prcd_pkg::*;

   prcd_ratio_t n_eff;
   prcd_ratio_t half_n;
   prcd_ratio_t cnt_q;
   prcd_ratio_t cnt_d;
   logic [1:0] clk_q;

   // ratios below two cannot come from a flop, so they are raised to two
   assign n_eff = (ratio < `PRCD_LB_DIV_MIN) ? `PRCD_LB_DIV_MIN : ratio;
   assign half_n = n_eff >> 1;
   assign cnt_d = (cnt_q >= n_eff - 5'h01) ? 5'h00 : cnt_q + 5'h01;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 5'h00;
         clk_q <= 2'h0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= (cnt_d < half_n) ? 2'h3 : 2'h0;
      end
   end

   assign clk_out = clk_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_lb_period_wrap: assert property ($past(cnt_q) == $past(n_eff) - 5'h01 && $stable(n_eff) |-> cnt_q == 5'h00)
      else $error("local bus divider did not wrap at its ratio");
   a_lb_high_phase: assert property (cnt_q == 5'h00 && $past(cnt_q) != 5'h00 |-> clk_q == 2'h3)
      else $error("local bus clock not high at start of period");

endmodule : prcd_lb_div

`default_nettype wire

// ### logic/prcd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "prcd_defines.svh"

module prcd_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // reset configuration word fields
   input wire prcd_pkg::prcd_ratio_t platform_ratio_field,
   input wire logic [1:0] platform_range_field,
   input wire prcd_pkg::prcd_ratio_t cluster_ratio_field_1,
   input wire logic [1:0] cluster_range_field_1,
   input wire prcd_pkg::prcd_ratio_t cluster_ratio_field_2,
   input wire logic [1:0] cluster_range_field_2,
   input wire logic [15:0] complex_source_select,
   input wire prcd_pkg::prcd_ratio_t memory_ratio_field,
   input wire logic [1:0] memory_range_field,
   input wire logic memory_sync_bit,
   input wire logic memory_rate_bit,
   input wire logic memory_reserved_bit,
   // decoded clocking
   output logic [4:0] platform_mult,
   output logic [4:0] cluster_mult_1,
   output logic [4:0] cluster_mult_2,
   output logic [3:0] core_from_two,
   output logic [3:0] core_div2,
   output logic mem_async,
   output logic [4:0] mem_data_mult,
   output logic config_error,
   // derived clocks
   output logic mem_bus_clk,
   output logic pattern_engine_clk,
   output logic [1:0] local_bus_clock_out
);
   import prcd_pkg::*;

   // range check shared by platform and cluster fields
   function automatic prcd_ratio_t range_mult(input prcd_ratio_t code, input prcd_ratio_t lo,
                                              input prcd_ratio_t hi);
      range_mult = (code >= lo && code <= hi) ? code : 5'h00;
   endfunction : range_mult

   // source select for one complex: {valid, from cluster two, divide by two}
   function automatic logic [2:0] src_decode(input logic [3:0] sel, input logic upper);
      src_decode = 3'h0;
      if (sel == `PRCD_SRC_ONE_DIV1) begin
         src_decode = 3'b100;
      end else if (sel == `PRCD_SRC_TWO_DIV1) begin
         src_decode = 3'b110;
      end else if (!upper && sel == `PRCD_SRC_ONE_DIV2) begin
         src_decode = 3'b101;
      end else if (upper && sel == `PRCD_SRC_TWO_DIV2) begin
         src_decode = 3'b111;
      end
   endfunction : src_decode

   // core slower than platform: cluster/div below platform multiplier
   function automatic logic core_slow(input prcd_ratio_t cm, input prcd_ratio_t pm, input logic div2);
      core_slow = div2 ? ({1'b0, cm} < {pm, 1'b0}) : (cm < pm);
   endfunction : core_slow

   // asynchronous memory ratio table
   function automatic prcd_ratio_t mem_async_mult(input prcd_ratio_t code);
      case (code)
         5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10, 5'h12, 5'h14: mem_async_mult = code;
         default: mem_async_mult = 5'h00;
      endcase
   endfunction : mem_async_mult

   // capture state
   logic done_q;
   logic [31:0] cap0_q;
   logic [31:0] cap1_q;
   prcd_ratio_t plat_q;
   prcd_ratio_t cl1_q;
   prcd_ratio_t cl2_q;
   logic [3:0] from_two_q;
   logic [3:0] div2_q;
   logic async_q;
   prcd_ratio_t memm_q;
   logic err_q;
   logic [3:0] slow_q;
   logic mem_clk_q;
   logic pe_clk_q;

   // decode of the live fields, stored only on the capture edge
   prcd_ratio_t plat_d;
   prcd_ratio_t cl1_d;
   prcd_ratio_t cl2_d;
   logic [2:0] src_d [4];
   prcd_ratio_t memm_d;
   wire mem_sync_w = memory_sync_bit;
   wire mode_bad_w = (memory_sync_bit != memory_rate_bit) || memory_reserved_bit;
   wire [3:0] src_bad_w;
   wire [3:0] slow_w;
   wire err_d;

   assign plat_d = range_mult(platform_ratio_field, `PRCD_PLAT_MIN, `PRCD_PLAT_MAX);
   assign cl1_d = range_mult(cluster_ratio_field_1, `PRCD_CL_MIN, `PRCD_CL_MAX);
   assign cl2_d = range_mult(cluster_ratio_field_2, `PRCD_CL_MIN, `PRCD_CL_MAX);
   assign src_d[0] = src_decode(complex_source_select[3:0], 1'b0);
   assign src_d[1] = src_decode(complex_source_select[7:4], 1'b0);
   assign src_d[2] = src_decode(complex_source_select[11:8], 1'b1);
   assign src_d[3] = src_decode(complex_source_select[15:12], 1'b1);
   // synchronous mode: only the 1:1 code, data rate equals platform
   assign memm_d = mem_sync_w ? ((memory_ratio_field == `PRCD_MEM_SYNC_CODE) ? 5'h01 : 5'h00)
                              : mem_async_mult(memory_ratio_field);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_core
         assign src_bad_w[gi] = !src_d[gi][2];
         assign slow_w[gi] = core_slow(src_d[gi][1] ? cl2_d : cl1_d, plat_d, src_d[gi][0]);
      end
   endgenerate

   assign err_d = (plat_d == 5'h00) || (cl1_d == 5'h00) || (cl2_d == 5'h00) || (|src_bad_w)
                  || (memm_d == 5'h00) || mode_bad_w;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= 1'b0;
         cap0_q <= 32'h0000_0000;
         cap1_q <= 32'h0000_0000;
      end else if (!done_q) begin
         done_q <= 1'b1;
         cap0_q <= {9'h000, cluster_range_field_2, cluster_ratio_field_2, 1'b0, cluster_range_field_1,
                    cluster_ratio_field_1, 1'b0, platform_range_field, platform_ratio_field};
         cap1_q <= {5'h00, memory_reserved_bit, memory_rate_bit, memory_sync_bit, 1'b0, memory_range_field,
                    memory_ratio_field, complex_source_select};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         plat_q <= 5'h00;
         cl1_q <= 5'h00;
         cl2_q <= 5'h00;
         memm_q <= 5'h00;
         async_q <= 1'b0;
         err_q <= 1'b0;
         slow_q <= 4'h0;
      end else if (!done_q) begin
         plat_q <= plat_d;
         cl1_q <= cl1_d;
         cl2_q <= cl2_d;
         memm_q <= memm_d;
         async_q <= !mem_sync_w;
         err_q <= err_d;
         slow_q <= slow_w;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         from_two_q <= 4'h0;
         div2_q <= 4'h0;
      end else if (!done_q) begin
         from_two_q <= {src_d[3][1], src_d[2][1], src_d[1][1], src_d[0][1]};
         div2_q <= {src_d[3][0], src_d[2][0], src_d[1][0], src_d[0][0]};
      end
   end

   // derived clocks: toggles give half the platform rate
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_clk_q <= 1'b0;
         pe_clk_q <= 1'b0;
      end else begin
         mem_clk_q <= done_q && !async_q && !mem_clk_q;
         pe_clk_q <= !pe_clk_q;
      end
   end

   // ahb-lite slave with one wait state so read data leave a flop
   prcd_bus_state_t state_q;
   logic [7:0] addr_q;
   logic wr_q;
   logic rdy_q;
   logic [31:0] rdata_q;
   prcd_ratio_t lb_div_q;
   wire accept_w = hsel && htrans[1] && hready && (state_q == PRCD_BUS_IDLE);
   wire in_data_w = (state_q == PRCD_BUS_DATA);
   wire sel_lb_w = (addr_q == `PRCD_OFS_LBCTRL);
   wire lb_wr_w = in_data_w && wr_q && sel_lb_w;
   wire [31:0] mults_w = {3'h0, memm_q, 3'h0, cl2_q, 3'h0, cl1_q, 3'h0, plat_q};
   wire [31:0] cores_w = {23'h00_0000, async_q, from_two_q, div2_q};
   wire [31:0] status_w = {24'h00_0000, slow_q, 1'b0, !async_q, err_q, done_q};
   wire [31:0] lbreg_w = {27'h000_0000, lb_div_q};
   wire [31:0] rmux_w;

   assign rmux_w = (addr_q == `PRCD_OFS_CAPTURE0) ? cap0_q :
                   (addr_q == `PRCD_OFS_CAPTURE1) ? cap1_q :
                   (addr_q == `PRCD_OFS_MULTS) ? mults_w :
                   (addr_q == `PRCD_OFS_CORES) ? cores_w :
                   (addr_q == `PRCD_OFS_STATUS) ? status_w :
                   sel_lb_w ? lbreg_w : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= PRCD_BUS_IDLE;
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rdy_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            PRCD_BUS_IDLE: begin
               if (accept_w) begin
                  addr_q <= (haddr[31:8] == 24'h00_0000) ? {haddr[7:2], 2'b00} : 8'hFF;
                  wr_q <= hwrite;
                  rdy_q <= 1'b0;
                  state_q <= PRCD_BUS_DATA;
               end
            end
            PRCD_BUS_DATA: begin
               rdata_q <= wr_q ? 32'h0000_0000 : rmux_w;
               rdy_q <= 1'b1;
               state_q <= PRCD_BUS_IDLE;
            end
            default: begin
               state_q <= PRCD_BUS_IDLE;
               rdy_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lb_div_q <= `PRCD_LB_DIV_RST;
      end else if (lb_wr_w) begin
         lb_div_q <= hwdata[`PRCD_LB_DIV_LSB +: 5];
      end
   end

   prcd_lb_div u_lb_div (
      .clock(clock),
      .rst_b(rst_b),
      .ratio(lb_div_q),
      .clk_out(local_bus_clock_out)
   );

   assign hreadyout = rdy_q;
   assign hrdata = rdata_q;
   assign hresp = 1'b0;
   assign platform_mult = plat_q;
   assign cluster_mult_1 = cl1_q;
   assign cluster_mult_2 = cl2_q;
   assign core_from_two = from_two_q;
   assign core_div2 = div2_q;
   assign mem_async = async_q;
   assign mem_data_mult = memm_q;
   assign config_error = err_q;
   assign mem_bus_clk = mem_clk_q;
   assign pattern_engine_clk = pe_clk_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_plat_decode: assert property ($rose(done_q) |-> plat_q == range_mult($past(platform_ratio_field),
      `PRCD_PLAT_MIN, `PRCD_PLAT_MAX)) else $error("platform multiplier mismatch");
   a_cluster_decode: assert property ($rose(done_q) && $past(cluster_ratio_field_1) == 5'h12
      |-> cl1_q == 5'h12) else $error("cluster multiplier 18 not decoded");
   a_cluster_frozen: assert property (done_q |=> $stable(cl1_q) && $stable(cl2_q))
      else $error("cluster multiplier changed after capture");
   a_src_low_pair: assert property ($rose(done_q) && $past(complex_source_select[3:0]) == 4'h1
      |-> !from_two_q[0] && div2_q[0]) else $error("complex zero source decode wrong");
   a_src_high_pair: assert property ($rose(done_q) && $past(complex_source_select[11:8]) == 4'h5
      |-> from_two_q[2] && div2_q[2]) else $error("complex two source decode wrong");
   a_mem_half_rate: assert property (done_q && !async_q ##1 1 |-> mem_clk_q != $past(mem_clk_q))
      else $error("memory bus clock not half platform in sync mode");
   a_mem_async_idle: assert property (async_q |-> ##[0:1] !mem_clk_q)
      else $error("memory bus clock driven in async mode");
   a_mem_table: assert property ($rose(done_q) && $past(memory_ratio_field) == 5'h0D
      && !$past(memory_sync_bit) |-> memm_q == 5'h0D) else $error("ratio 13 lost");
   a_sync_only_one: assert property ($rose(done_q) && $past(memory_sync_bit)
      && $past(memory_ratio_field) != 5'h01 |-> err_q && memm_q == 5'h00) else $error("bad sync code accepted");
   a_pe_toggle: assert property (pe_clk_q |=> !pe_clk_q ##1 pe_clk_q)
      else $error("pattern engine clock not half rate");
   a_cfg_reserved: assert property ($rose(done_q) && $past(complex_source_select[7:4]) == 4'h2
      |-> err_q) else $error("reserved source code not flagged");
   a_bus_wait_one: assert property (accept_w |=> !rdy_q ##1 rdy_q)
      else $error("bus answer not after one wait state");

   c_sync_mode: cover property ($rose(done_q) && !async_q);
   c_config_err: cover property ($rose(done_q) && err_q);
   c_lb_write: cover property (lb_wr_w);
   c_core_div2: cover property ($rose(done_q) && |div2_q);

endmodule : prcd_top

`default_nettype wire

// ### dv/prcd_cfg_source.sv
`timescale 1ns/10ps
`default_nettype none

module prcd_cfg_source #(
   parameter int REF_KHZ = 100000
) (
   // requested setup
   input wire logic [4:0] plat_code,
   input wire logic [4:0] cl1_code,
   input wire logic [4:0] cl2_code,
   input wire logic [15:0] sel_code,
   input wire logic [4:0] mem_code,
   input wire logic sync_mode,
   input wire logic scramble,
   // configuration word fields
   output logic [4:0] plat_ratio,
   output logic [1:0] plat_range,
   output logic [4:0] cl1_ratio,
   output logic [1:0] cl1_range,
   output logic [4:0] cl2_ratio,
   output logic [1:0] cl2_range,
   output logic [15:0] src_sel,
   output logic [4:0] mem_ratio,
   output logic [1:0] mem_range,
   output logic sync_bit,
   output logic rate_bit,
   output logic rsv_bit
);
   // reference cutoff in khz per async ratio
   function automatic int mem_cut(input logic [4:0] c);
      case (c)
         5'h05, 5'h0A: return 96700;
         5'h06, 5'h0C: return 80600;
         5'h08: return 120900;
         5'h09: return 107400;
         5'h0D: return 74400;
         5'h10: return 60400;
         5'h12: return 53700;
         default: return 48400;
      endcase
   endfunction : mem_cut

   logic [4:0] flip;
   // fields only move after capture when told to
   assign flip = {5{scramble}};
   assign plat_ratio = plat_code ^ flip;
   assign plat_range = 2'h1;
   assign cl1_ratio = cl1_code ^ flip;
   assign cl1_range = (int'(cl1_code) * REF_KHZ >= 1000000) ? 2'h0 : 2'h1;
   assign cl2_ratio = cl2_code ^ flip;
   assign cl2_range = (int'(cl2_code) * REF_KHZ >= 1000000) ? 2'h0 : 2'h1;
   assign src_sel = sel_code ^ {16{scramble}};
   assign mem_ratio = mem_code ^ flip;
   assign mem_range = (sync_mode ? int'(plat_code) * REF_KHZ > 600000 : REF_KHZ > mem_cut(mem_code))
                      ? 2'h1 : 2'h0;
   assign sync_bit = sync_mode;
   assign rate_bit = sync_mode;
   assign rsv_bit = 1'b0;
endmodule : prcd_cfg_source

`default_nettype wire

// ### dv/prcd_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "prcd_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end

module prcd_top_bench;
   import prcd_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   // initial setup keeps cores at or above platform
   logic [4:0] pc = 5'h06, c1 = 5'h0A, c2 = 5'h0C, mc = 5'h08;
   logic [15:0] sc = 16'h0;
   logic sy = 1'b0, scr = 1'b0;
   logic hreadyout, hresp, mem_async, config_error, mem_bus_clk, pattern_engine_clk, f_sy, f_rt, f_rs;
   logic [31:0] hrdata;
   logic [4:0] platform_mult, cluster_mult_1, cluster_mult_2, mem_data_mult, f_p, f_c1, f_c2, f_m;
   logic [3:0] core_from_two, core_div2;
   logic [1:0] local_bus_clock_out, g_p, g_c1, g_c2, g_m;
   logic [15:0] f_s;
   int bad_count = 0;
   int checks = 0;

   prcd_cfg_source src_u (.plat_code(pc), .cl1_code(c1), .cl2_code(c2), .sel_code(sc), .mem_code(mc),
      .sync_mode(sy), .scramble(scr), .plat_ratio(f_p), .plat_range(g_p), .cl1_ratio(f_c1), .cl1_range(g_c1),
      .cl2_ratio(f_c2), .cl2_range(g_c2), .src_sel(f_s), .mem_ratio(f_m), .mem_range(g_m), .sync_bit(f_sy),
      .rate_bit(f_rt), .rsv_bit(f_rs));
   prcd_top dut_u (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .platform_ratio_field(f_p), .platform_range_field(g_p), .cluster_ratio_field_1(f_c1),
      .cluster_range_field_1(g_c1), .cluster_ratio_field_2(f_c2), .cluster_range_field_2(g_c2),
      .complex_source_select(f_s), .memory_ratio_field(f_m), .memory_range_field(g_m), .memory_sync_bit(f_sy),
      .memory_rate_bit(f_rt), .memory_reserved_bit(f_rs), .platform_mult(platform_mult),
      .cluster_mult_1(cluster_mult_1), .cluster_mult_2(cluster_mult_2), .core_from_two(core_from_two),
      .core_div2(core_div2), .mem_async(mem_async), .mem_data_mult(mem_data_mult), .config_error(config_error),
      .mem_bus_clk(mem_bus_clk), .pattern_engine_clk(pattern_engine_clk), .local_bus_clock_out(local_bus_clock_out));

   initial begin
      forever #50 clock = ~clock;
   end

   task automatic end_of_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask : wait_ready

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb

   task automatic boot(input logic [4:0] p, a, b, m, input logic [15:0] s, input logic y);
      @(posedge clock);
      rst_b <= 1'b0;
      pc <= p;
      c1 <= a;
      c2 <= b;
      mc <= m;
      sc <= s;
      sy <= y;
      scr <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
   endtask : boot

   task automatic t_lb(input logic [4:0] d, input int n);
      logic [31:0] rd;
      logic pv;
      int hi, rises;
      ahb(1'b1, 32'(`PRCD_OFS_LBCTRL), {27'h0, d}, rd);
      repeat (20) @(negedge clock);
      pv = local_bus_clock_out[0];
      hi = 0;
      rises = 0;
      repeat (4 * n) begin
         @(negedge clock);
         hi += local_bus_clock_out[0];
         rises += local_bus_clock_out[0] & ~pv;
         pv = local_bus_clock_out[0];
         `CHK(local_bus_clock_out[1], local_bus_clock_out[0])
      end
      `CHK(hi, 4 * (n / 2))
      `CHK(rises, 4)
      @(posedge clock);
   endtask : t_lb

   task automatic t_regs();
      logic [31:0] rd;
      ahb(1'b0, 32'(`PRCD_OFS_LBCTRL), 32'h0, rd);
      `CHK(rd[4:0], `PRCD_LB_DIV_RST)
      ahb(1'b0, 32'h0000_0100, 32'h0, rd);
      `CHK(rd, 32'h0)
      ahb(1'b1, 32'(`PRCD_OFS_MULTS), 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'(`PRCD_OFS_MULTS), 32'h0, rd);
      `CHK(rd, 32'h080C_0A06)
      t_lb(5'h03, 3);
      ahb(1'b0, 32'(`PRCD_OFS_LBCTRL), 32'h0, rd);
      `CHK(rd[4:0], 5'h03)
      t_lb(5'h01, 2);
      t_lb(5'h08, 8);
   endtask : t_regs

   task automatic t_ratios();
      logic [4:0] ep, e1, e2, em;
      logic [31:0] rd;
      for (int i = 0; i < 32; i++) begin
         boot(5'(i), 5'(i), 5'(31 - i), 5'(i), 16'h0, 1'b0);
         ep = (i >= 4 && i <= 10) ? 5'(i) : 5'h0;
         e1 = (i >= 8 && i <= 18) ? 5'(i) : 5'h0;
         e2 = (31 - i >= 8 && 31 - i <= 18) ? 5'(31 - i) : 5'h0;
         em = (i inside {5, 6, 8, 9, 10, 12, 13, 16, 18, 20}) ? 5'(i) : 5'h0;
         `CHK(platform_mult, ep)
         `CHK(cluster_mult_1, e1)
         `CHK(cluster_mult_2, e2)
         `CHK(mem_data_mult, em)
         `CHK(config_error, (ep == 0 || e1 == 0 || e2 == 0 || em == 0))
         ahb(1'b0, 32'(`PRCD_OFS_MULTS), 32'h0, rd);
         `CHK(rd, ({3'h0, em, 3'h0, e2, 3'h0, e1, 3'h0, ep}))
      end
   endtask : t_ratios

   task automatic t_sources();
      logic [31:0] rd;
      logic lt, ld, ht, hd;
      for (int c = 0; c < 16; c++) begin
         // both clusters at twice the platform keep halved cores legal
         boot(5'h06, 5'h0C, 5'h0C, 5'h08, {4{4'(c)}}, 1'b0);
         lt = (c == 4);
         ld = (c == 1);
         ht = (c == 4 || c == 5);
         hd = (c == 5);
         `CHK(core_from_two, ({ht, ht, lt, lt}))
         `CHK(core_div2, ({hd, hd, ld, ld}))
         `CHK(config_error, !(c == 0 || c == 4))
      end
      boot(5'h06, 5'h0C, 5'h0C, 5'h08, 16'h5401, 1'b0);
      `CHK(config_error, 1'b0)
      ahb(1'b0, 32'(`PRCD_OFS_CORES), 32'h0, rd);
      `CHK(rd, 32'h0000_01C9)
      ahb(1'b0, 32'(`PRCD_OFS_STATUS), 32'h0, rd);
      `CHK(rd, 32'h0000_0001)
   endtask : t_sources

   task automatic t_toggle(input logic run);
      logic pm, pp;
      @(negedge clock);
      pm = mem_bus_clk;
      pp = pattern_engine_clk;
      repeat (8) begin
         @(negedge clock);
         `CHK(mem_bus_clk, (run ? ~pm : 1'b0))
         `CHK(pattern_engine_clk, ~pp)
         pm = mem_bus_clk;
         pp = pattern_engine_clk;
      end
      @(posedge clock);
   endtask : t_toggle

   task automatic t_modes();
      logic [31:0] rd;
      boot(5'h06, 5'h0A, 5'h0C, 5'h01, 16'h0, 1'b1);
      `CHK(mem_async, 1'b0)
      ahb(1'b0, 32'(`PRCD_OFS_STATUS), 32'h0, rd);
      `CHK(rd, 32'h0000_0005)
      `CHK(mem_data_mult, 5'h01)
      `CHK(config_error, 1'b0)
      t_toggle(1'b1);
      boot(5'h06, 5'h0A, 5'h0C, 5'h05, 16'h0, 1'b1);
      `CHK(mem_data_mult, 5'h00)
      `CHK(config_error, 1'b1)
      // data rate above platform needs the async mode
      boot(5'h07, 5'h09, 5'h11, 5'h10, 16'h0, 1'b0);
      `CHK(mem_async, 1'b1)
      t_toggle(1'b0);
   endtask : t_modes

   task automatic t_hold();
      logic [31:0] rd;
      boot(5'h07, 5'h09, 5'h11, 5'h10, 16'h0, 1'b0);
      scr <= 1'b1;
      repeat (4) @(posedge clock);
      `CHK(cluster_mult_1, 5'h09)
      `CHK(cluster_mult_2, 5'h11)
      `CHK(config_error, 1'b0)
      ahb(1'b0, 32'(`PRCD_OFS_CAPTURE0), 32'h0, rd);
      `CHK(rd, ({9'h0, 2'h0, 5'h11, 1'b0, 2'h1, 5'h09, 1'b0, 2'h1, 5'h07}))
      ahb(1'b0, 32'(`PRCD_OFS_CAPTURE1), 32'h0, rd);
      `CHK(rd, 32'h0030_0000)
   endtask : t_hold

   initial begin
      repeat (19) @(posedge clock);
      `CHK(hreadyout, 1'b1)
      `CHK(platform_mult, 5'h00)
      @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      t_regs();
      t_ratios();
      t_sources();
      t_modes();
      t_hold();
      end_of_test();
   end

   initial begin
      repeat (100000) @(posedge clock);
      bad_count++;
      end_of_test();
   end
endmodule : prcd_top_bench

`undef CHK
`default_nettype wire
